// >>> logic/mstx_translator.sv
`timescale 1ns/1ns
// What this block does
// RULE_01: Each step pulse rising edge advances the electrical angle one position.
// RULE_02: Mode bits: 00 full, bit0 half, bit1 eighth, both sixteenth.
// RULE_03: Mode change applies at once while outputs are enabled.
// RULE_04: Direction change takes effect at the next step rising edge.
// RULE_05: Direction low: clockwise, winding b lags winding a by 90 degrees.
// RULE_06: Direction high: counter-clockwise, winding b leads winding a by 90 degrees.
// RULE_07: Enable low turns all bridge transistors off; high makes outputs active.
// RULE_08: Enable low ignores steps, keeping angle and mode.
// RULE_09: Mode changed during enable low applies at enable rising edge.
// RULE_10: Power save low: standby, outputs open, translator held at start angle.
// RULE_11: Outputs become active within 40 us after power save rises.
// RULE_12: After reset the angle starts at 45 degrees in every mode.
// RULE_13: Full step current target is scaled by 0.7071.
// RULE_14: Test input must be held at ground by the system.
// RULE_15: Each winding gets a 4-bit current code for its DAC.
// RULE_16: Increment 90, 45, 11.25, 5.625 degrees by mode, wrapping at 360.
module mstx_translator (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   // Factory test input, held low by the system
   input  wire logic        i_test,
   // AXI4-Lite write address and data
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [3:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // AXI4-Lite write response
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // AXI4-Lite read
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [3:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // Winding a bridge and DAC
   output logic [3:0]       o_winding_a_dac,
   output logic             o_winding_a_neg,
   output logic             o_winding_a_drive,
   // Winding b bridge and DAC
   output logic [3:0]       o_winding_b_dac,
   output logic             o_winding_b_neg,
   output logic             o_winding_b_drive,
   // Translator state
   output logic [5:0]       o_angle,
   output mstx_pkg::mstx_mode_type o_mode
);
   import mstx_pkg::*;

   typedef struct packed {
      logic [5:0]    angle;
      mstx_mode_type mode;
      logic          step_d;
      logic          enable_d;
      logic          awake;
      logic [15:0]   wake_count;
      logic          drive;
   } mstx_core_type;

   mstx_core_type state;
   mstx_core_type next_state;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   logic [5:0]  control;
   logic        step_write;
   logic [31:0] status_word;
   logic [31:0] angle_word;
   logic [31:0] dac_word;
   logic [3:0]  dac_a;
   logic [3:0]  dac_b;
   logic        neg_a;
   logic        neg_b;

   mstx_axil u_axil (
      .i_clock      (i_clock),
      .i_rstn       (i_rstn),
      .i_awvalid    (i_awvalid),
      .o_awready    (o_awready),
      .i_awaddr     (i_awaddr),
      .i_wvalid     (i_wvalid),
      .o_wready     (o_wready),
      .i_wdata      (i_wdata),
      .i_wstrb      (i_wstrb),
      .o_bvalid     (o_bvalid),
      .i_bready     (i_bready),
      .o_bresp      (o_bresp),
      .i_arvalid    (i_arvalid),
      .o_arready    (o_arready),
      .i_araddr     (i_araddr),
      .o_rvalid     (o_rvalid),
      .i_rready     (i_rready),
      .o_rdata      (o_rdata),
      .o_rresp      (o_rresp),
      .o_control    (control),
      .o_step_pulse (step_write),
      .i_status     (status_word),
      .i_angle      (angle_word),
      .i_dac        (dac_word)
   );

   // ----------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------
   logic          step_in;
   logic          dir_in;
   logic          enable_in;
   logic          power_save_n;
   mstx_mode_type mode_sel;
   logic [5:0]    increment;

   // Step comes from the self-clearing bit; pulses count as edges
   assign step_in      = step_write;
   assign dir_in       = control[CTL_DIR];
   assign enable_in    = control[CTL_ENABLE];
   assign power_save_n = control[CTL_PSN];
   assign mode_sel     = mstx_decode(control[CTL_STEP_MODE_BIT0], control[CTL_STEP_MODE_BIT1]);   // RULE_02

   // Angle step size of the mode in force
   always_comb begin
      case (state.mode)
         MSTX_FULL:   increment = INC_FULL;        // RULE_16
         MSTX_HALF:   increment = INC_HALF;        // RULE_16
         MSTX_EIGHTH: increment = INC_EIGHTH;      // RULE_16
         default:     increment = INC_SIXTEENTH;   // RULE_16
      endcase
   end

   // ----------------------------------------------------------------
   // Translator
   // ----------------------------------------------------------------
   // Direction is read only on a step edge, so a change waits for it
   always_comb begin
      next_state          = state;
      next_state.step_d   = step_in;
      next_state.enable_d = enable_in;
      if (!power_save_n) begin
         // Standby: translator held at its start angle, mode follows the bits
         next_state.angle      = ANGLE_START;   // RULE_10
         next_state.mode       = mode_sel;
         next_state.awake      = 1'b0;          // RULE_10
         next_state.wake_count = '0;
      end else begin
         if (!state.awake) begin
            // Outputs wait out the wake-up time
            if (state.wake_count >= 16'(WAKE_CYCLES - 1)) begin
               next_state.awake = 1'b1;   // RULE_11
            end else begin
               next_state.wake_count = 16'(state.wake_count + 16'h0001);
            end
         end
         if (enable_in) begin
            // Mode follows the bits at once while enabled, also on enable rise
            next_state.mode = mode_sel;   // RULE_03 RULE_09
            if (step_in && !state.step_d) begin
               if (dir_in) begin
                  next_state.angle = 6'(state.angle - increment);   // RULE_01 RULE_04 RULE_06
               end else begin
                  next_state.angle = 6'(state.angle + increment);   // RULE_01 RULE_04 RULE_05
               end
            end
         end
         // Enable low: steps ignored, angle and mode kept   RULE_08
      end
      next_state.drive = enable_in && power_save_n && next_state.awake;   // RULE_07 RULE_10
   end

   // State register
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state       <= '0;
         state.angle <= ANGLE_START;   // RULE_12
         state.mode  <= MSTX_FULL;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Current waveform
   // ----------------------------------------------------------------
   mstx_wave u_wave (
      .i_clock    (i_clock),
      .i_rstn     (i_rstn),
      .i_angle    (state.angle),
      .i_fullstep (state.mode == MSTX_FULL),
      .o_dac_a    (dac_a),
      .o_neg_a    (neg_a),
      .o_dac_b    (dac_b),
      .o_neg_b    (neg_b)
   );

   // Read-back words; test input shown for visibility only
   assign status_word = {24'h000000, i_test, state.drive, state.awake, 1'b0,
                         state.enable_d, state.mode, state.step_d};
   assign angle_word  = {26'h0000000, state.angle};
   assign dac_word    = {22'h000000, neg_b, dac_b, neg_a, dac_a};

   // ----------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign o_winding_a_dac   = dac_a;
   assign o_winding_a_neg   = neg_a;
   assign o_winding_a_drive = state.drive;   // RULE_07
   assign o_winding_b_dac   = dac_b;
   assign o_winding_b_neg   = neg_b;
   assign o_winding_b_drive = state.drive;   // RULE_07
   assign o_angle           = state.angle;
   assign o_mode            = state.mode;

endmodule // mstx_translator

// >>> logic/mstx_pkg.sv
package mstx_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_HZ          = 10_000_000;
   localparam int unsigned WAKE_TIME_NS      = 40_000;
   // Wake-up wait in cycles, rounded down so it never exceeds the limit
   localparam int unsigned WAKE_CYCLES       = WAKE_TIME_NS / (1_000_000_000 / CLOCK_HZ);

   // ----------------------------------------------------------------
   // Angle representation: 64 steps of 5.625 deg per turn
   // ----------------------------------------------------------------
   localparam int unsigned ANGLE_W           = 6;
   localparam logic [5:0]  ANGLE_START       = 6'h08;    // 45 deg
   localparam logic [5:0]  INC_FULL          = 6'h10;    // 90 deg
   localparam logic [5:0]  INC_HALF          = 6'h08;    // 45 deg
   localparam logic [5:0]  INC_EIGHTH        = 6'h02;    // 11.25 deg
   localparam logic [5:0]  INC_SIXTEENTH     = 6'h01;    // 5.625 deg
   localparam int unsigned DAC_W             = 4;
   localparam logic [3:0]  DAC_FULLSTEP_CODE = 4'hB;     // Near 0.7071 of full scale

   // ----------------------------------------------------------------
   // Register map (AXI4-Lite byte offsets)
   // ----------------------------------------------------------------
   localparam logic [3:0]  OFS_CONTROL       = 4'h0;
   localparam logic [3:0]  OFS_STATUS        = 4'h4;
   localparam logic [3:0]  OFS_ANGLE         = 4'h8;
   localparam logic [3:0]  OFS_DAC           = 4'hC;
   localparam int unsigned CTL_STEP          = 0;   // Write 1: one step pulse
   localparam int unsigned CTL_DIR           = 1;
   localparam int unsigned CTL_STEP_MODE_BIT0         = 2;
   localparam int unsigned CTL_STEP_MODE_BIT1         = 3;
   localparam int unsigned CTL_ENABLE        = 4;
   localparam int unsigned CTL_PSN           = 5;
   localparam logic [5:0]  CONTROL_RESET     = 6'h00;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   typedef enum logic [1:0] {
      MSTX_FULL,
      MSTX_HALF,
      MSTX_EIGHTH,
      MSTX_SIXTEENTH
   } mstx_mode_type;

   // Mode bits to step mode
   function automatic mstx_mode_type mstx_decode(input logic bit0, input logic bit1);
      mstx_mode_type m;
      m = MSTX_FULL;
      case ({bit1, bit0})
         2'h0:    m = MSTX_FULL;
         2'h1:    m = MSTX_HALF;
         2'h2:    m = MSTX_EIGHTH;
         default: m = MSTX_SIXTEENTH;
      endcase
      return m;
   endfunction

endpackage

// >>> logic/mstx_axil.sv
`timescale 1ns/1ns
// AXI4-Lite slave holding the control bits and reading back state
module mstx_axil (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   // Write address and data
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [3:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // Write response
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // Read
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [3:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // Block side
   output logic [5:0]       o_control,
   output logic             o_step_pulse,
   input  wire logic [31:0] i_status,
   input  wire logic [31:0] i_angle,
   input  wire logic [31:0] i_dac
);
   import mstx_pkg::*;

   typedef struct packed {
      logic        aw_held;
      logic [3:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [5:0]  control;
      logic        step;
   } mstx_axil_type;

   mstx_axil_type state;
   mstx_axil_type next_state;

   // ----------------------------------------------------------------
   // Channel handling
   // ----------------------------------------------------------------
   // Address and data may arrive in either order; a held item blocks more
   always_comb begin
      next_state      = state;
      next_state.step = 1'b0;
      if (i_awvalid && !state.aw_held) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = i_awaddr;
      end
      if (i_wvalid && !state.w_held) begin
         next_state.w_held = 1'b1;
         next_state.w_data = i_wdata;
         next_state.w_strb = i_wstrb;
      end
      if (state.aw_held && state.w_held && !state.bvalid) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = RESP_OKAY;
         if (state.aw_addr == OFS_CONTROL) begin
            if (state.w_strb[0]) begin
               next_state.control = state.w_data[5:0];
               next_state.step    = state.w_data[CTL_STEP];
               next_state.control[CTL_STEP] = 1'b0;   // Step bit is self-clearing
            end
         end else if (state.aw_addr != OFS_STATUS && state.aw_addr != OFS_ANGLE
                      && state.aw_addr != OFS_DAC) begin
            next_state.bresp = RESP_SLVERR;
         end
      end
      if (state.bvalid && i_bready) begin
         next_state.bvalid = 1'b0;
      end
      // Reads answer one cycle after the address is taken
      if (i_arvalid && !state.rvalid) begin
         next_state.rvalid = 1'b1;
         next_state.rresp  = RESP_OKAY;
         case (i_araddr)
            OFS_CONTROL: next_state.rdata = {26'h0000000, state.control};
            OFS_STATUS:  next_state.rdata = i_status;
            OFS_ANGLE:   next_state.rdata = i_angle;
            OFS_DAC:     next_state.rdata = i_dac;
            default: begin
               next_state.rdata = 32'h00000000;
               next_state.rresp = RESP_SLVERR;
            end
         endcase
      end else if (state.rvalid && i_rready) begin
         next_state.rvalid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state         <= '0;
         state.control <= CONTROL_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign o_awready    = !state.aw_held;
   assign o_wready     = !state.w_held;
   assign o_bvalid     = state.bvalid;
   assign o_bresp      = state.bresp;
   assign o_arready    = !state.rvalid;
   assign o_rvalid     = state.rvalid;
   assign o_rdata      = state.rdata;
   assign o_rresp      = state.rresp;
   assign o_control    = state.control;
   assign o_step_pulse = state.step;

endmodule // mstx_axil

// >>> logic/mstx_wave.sv
`timescale 1ns/1ns
// Angle to signed 4-bit current code per winding (one quarter-wave table)
module mstx_wave (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   // Angle and mode in
   input  wire logic [5:0]  i_angle,
   input  wire logic        i_fullstep,
   // Per winding: magnitude code and polarity
   output logic [3:0]       o_dac_a,
   output logic             o_neg_a,
   output logic [3:0]       o_dac_b,
   output logic             o_neg_b
);
   import mstx_pkg::*;

   typedef struct packed {
      logic [3:0] dac_a;
      logic       neg_a;
      logic [3:0] dac_b;
      logic       neg_b;
   } mstx_wave_type;

   mstx_wave_type state;
   mstx_wave_type next_state;

   // Sine magnitude, 16 steps per quarter, full scale 15, one nibble per step
   localparam logic [63:0] SINE_TABLE = 64'hFFEEDCCB_98764310;

   function automatic logic [3:0] mstx_sine(input logic [5:0] ang);
      logic [3:0] idx;
      logic [3:0] mag;
      idx = ang[4] ? 4'(5'h10 - {1'b0, ang[3:0]}) : ang[3:0];
      mag = SINE_TABLE[{idx, 2'b00} +: 4];
      // Peak of quarter wave: index wraps to 0 when ang[3:0] is 0 in odd quarter
      if (ang[4] && ang[3:0] == 4'h0) begin
         mag = 4'hF;
      end
      return mag;
   endfunction

   // Winding a follows cosine, b sine: b lags a while the angle rises
   always_comb begin
      logic [5:0] ang_a;
      ang_a            = 6'(i_angle + 6'h10);
      next_state.dac_a = mstx_sine(ang_a);   // RULE_05 RULE_06
      next_state.neg_a = ang_a[5];
      next_state.dac_b = mstx_sine(i_angle);
      next_state.neg_b = i_angle[5];
      if (i_fullstep) begin
         // Full step runs at the 0.7071 level on both windings
         next_state.dac_a = DAC_FULLSTEP_CODE;   // RULE_13
         next_state.dac_b = DAC_FULLSTEP_CODE;   // RULE_13
      end
   end

   // State register
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_dac_a = state.dac_a;   // RULE_15
   assign o_neg_a = state.neg_a;
   assign o_dac_b = state.dac_b;   // RULE_15
   assign o_neg_b = state.neg_b;

endmodule // mstx_wave

// >>> bench/mstx_translator_properties.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port checks of the step translator
// ----------------------------------------------------------------
module mstx_translator_properties (
   // Clock, reset and bus handshakes
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   input  wire logic        i_awvalid,
   input  wire logic        o_awready,
   input  wire logic        i_wvalid,
   input  wire logic        o_wready,
   input  wire logic        o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [1:0]  o_bresp,
   input  wire logic        i_arvalid,
   input  wire logic        o_arready,
   input  wire logic        o_rvalid,
   input  wire logic        i_rready,
   input  wire logic [31:0] o_rdata,
   // Bridges and translator state
   input  wire logic [3:0]  o_winding_a_dac,
   input  wire logic [3:0]  o_winding_b_dac,
   input  wire logic        o_winding_a_drive,
   input  wire logic        o_winding_b_drive,
   input  wire logic [5:0]  o_angle,
   input  wire mstx_pkg::mstx_mode_type o_mode
);
   import mstx_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   logic [9:0] since_wr;
   // Step size per mode, own table so a wrong package value shows
   function automatic logic [5:0] inc_of(input mstx_mode_type m);
      return (m == MSTX_FULL) ? 6'h10 : (m == MSTX_HALF) ? 6'h08 : (m == MSTX_EIGHTH) ? 6'h02 : 6'h01;
   endfunction
   // Cycles since the last write response; saturates so it never wraps
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) since_wr <= 10'h000;
      else if (o_bvalid && i_bready) since_wr <= 10'h000;
      else if (since_wr != 10'h3FF) since_wr <= since_wr + 10'h001;
   end
   a_drive_pair_equal: assert property (o_winding_a_drive == o_winding_b_drive)
      else $error("bridge drives differ");
   a_start_angle: assert property (!$past(i_rstn) |-> o_angle == ANGLE_START)
      else $error("angle not at start after reset");
   a_angle_step_size: assert property ($changed(o_angle) |-> o_angle == ANGLE_START
      || 6'(o_angle - $past(o_angle)) == inc_of($past(o_mode)) || 6'($past(o_angle) - o_angle) == inc_of($past(o_mode)))
      else $error("angle moved by a wrong amount");
   a_full_dac_code: assert property (o_winding_a_drive && o_mode == MSTX_FULL && $past(o_mode) == MSTX_FULL
      && $past(i_rstn) |-> o_winding_a_dac == 4'hB && o_winding_b_dac == 4'hB)
      else $error("full step current code wrong");
   a_wake_within: assert property ($rose(o_winding_a_drive) |-> since_wr <= 10'h192)
      else $error("bridges came up too late");
   a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
      else $error("write response late");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("read response late");
   c_step_sixteenth: cover property (o_mode == MSTX_SIXTEENTH && $changed(o_angle));
   c_drive_rise: cover property ($rose(o_winding_a_drive));
   c_slow_bready: cover property (o_bvalid && !i_bready);
endmodule // mstx_translator_properties

bind mstx_translator mstx_translator_properties u_props (.*);

// >>> bench/mstx_host.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host controller: AXI4-Lite master, optionally slow to accept
// ----------------------------------------------------------------
module mstx_host (
   // Clock
   input  wire logic        i_clock,
   // Write channels
   output logic             o_awvalid,
   input  wire logic        i_awready,
   output logic [3:0]       o_awaddr,
   output logic             o_wvalid,
   input  wire logic        i_wready,
   output logic [31:0]      o_wdata,
   output logic [3:0]       o_wstrb,
   input  wire logic        i_bvalid,
   output logic             o_bready,
   // Read channels
   output logic             o_arvalid,
   input  wire logic        i_arready,
   output logic [3:0]       o_araddr,
   input  wire logic        i_rvalid,
   output logic             o_rready,
   input  wire logic [31:0] i_rdata,
   input  wire logic [1:0]  i_rresp,
   input  wire logic [1:0]  i_bresp
);
   int slow;
   // Idle bus at time zero
   initial begin
      slow = 0;
      {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
      {o_awaddr, o_araddr, o_wstrb, o_wdata} = 44'h0;
   end
   // One write; payload inverted once taken so stale data never looks valid
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      @(posedge i_clock);
      o_awvalid <= 1'b1;
      o_awaddr  <= a;
      o_wvalid  <= 1'b1;
      o_wdata   <= d;
      o_wstrb   <= 4'hF;
      forever begin
         @(posedge i_clock);
         if (o_awvalid && i_awready) o_awvalid <= 1'b0;
         if (o_awvalid && i_awready) o_awaddr <= ~a;
         if (o_wvalid && i_wready) o_wvalid <= 1'b0;
         if (o_wvalid && i_wready) o_wdata <= ~d;
         if (o_bready && i_bvalid) begin
            r = i_bresp;
            o_bready <= 1'b0;
            break;
         end
         if (k++ >= slow) o_bready <= 1'b1;
      end
   endtask
   // One read
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clock);
      o_arvalid <= 1'b1;
      o_araddr  <= a;
      o_rready  <= 1'b1;
      forever begin
         @(posedge i_clock);
         if (o_arvalid && i_arready) o_arvalid <= 1'b0;
         if (o_rready && i_rvalid) begin
            d = i_rdata;
            r = i_rresp;
            o_rready <= 1'b0;
            break;
         end
      end
   endtask
endmodule // mstx_host

// >>> bench/microstep_translator_tb.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Self-checking bench for the step translator
// ----------------------------------------------------------------
module microstep_translator_tb;
   import mstx_pkg::*;
   logic          i_clock, i_rstn, i_test, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
   logic          i_arvalid, o_arready, o_rvalid, i_rready, o_winding_a_neg, o_winding_b_neg;
   logic          o_winding_a_drive, o_winding_b_drive;
   logic [3:0]    i_awaddr, i_araddr, i_wstrb, o_winding_a_dac, o_winding_b_dac;
   logic [31:0]   i_wdata, o_rdata, seed, rd_val;
   logic [1:0]    o_bresp, o_rresp, resp;
   logic [5:0]    o_angle;
   mstx_mode_type o_mode;
   int            bad_count, cmp_count, m_angle, m_mode, m_bits, m_dir, m_en, m_psn, awake;
   int            inc[4] = '{16, 8, 2, 1};
   mstx_translator u_dut (.*);
   mstx_host u_host (.i_clock, .o_awvalid(i_awvalid), .i_awready(o_awready), .o_awaddr(i_awaddr),
      .o_wvalid(i_wvalid), .i_wready(o_wready), .o_wdata(i_wdata), .o_wstrb(i_wstrb), .i_bvalid(o_bvalid),
      .o_bready(i_bready), .i_bresp(o_bresp), .o_arvalid(i_arvalid), .i_arready(o_arready), .o_araddr(i_araddr),
      .i_rvalid(o_rvalid), .o_rready(i_rready), .i_rdata(o_rdata), .i_rresp(o_rresp));
   // 10 MHz clock
   initial i_clock = 1'b0;
   always #50 i_clock = ~i_clock;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
      u_host.rd(a, rd_val, resp);
      chk(rd_val, exp);
      chk(resp, er);
   endtask
   // Control write, model update, compare
   task automatic put(input int step);
      u_host.wr(OFS_CONTROL, 32'(step + m_dir * 2 + m_bits * 4 + m_en * 16 + m_psn * 32), resp);
      chk(resp, RESP_OKAY);
      if (m_en || !m_psn) m_mode = m_bits;
      if (step && m_en && m_psn) m_angle = (m_angle + (m_dir ? 64 - inc[m_mode] : inc[m_mode])) % 64;
      if (!m_psn) m_angle = 8;
      repeat (4) @(posedge i_clock);
      chk(o_angle, m_angle);
      chk({o_winding_a_neg, o_winding_b_neg}, {m_angle >= 16 && m_angle < 48, m_angle >= 32});
      chk(o_mode, m_mode);
      chk({o_winding_a_drive, o_winding_b_drive}, (m_en && awake) ? 2'h3 : 2'h0);
      if (m_mode == 0 && m_en && awake) chk({o_winding_a_dac, o_winding_b_dac}, 8'hBB);
   endtask
   // Watchdog: the run needs a few thousand cycles
   initial begin
      #(100 * 20000);
      bad_count++;
      results();
   end
   // Main sequence
   initial begin
      {i_rstn, i_test} = 2'h0;
      {bad_count, cmp_count, m_mode, m_bits, m_dir, m_en, m_psn, awake} = '0;
      m_angle = 8;
      seed = 32'h94bd1ee2;
      repeat (2) @(posedge i_clock);
      i_rstn <= 1'b1;
      @(posedge i_clock);
      chk(o_angle, 8);
      chk({o_winding_a_drive, o_winding_b_drive}, 2'h0);
      u_host.rd(OFS_STATUS, rd_val, resp);
      chk(rd_val[7], 1'b0);
      rchk(4'h2, 32'h0, RESP_SLVERR);
      // Wake up; the controller must wait out the start-up delay
      m_en = 1;
      m_psn = 1;
      put(0);
      repeat (300) @(posedge i_clock);
      chk({o_winding_a_drive, o_winding_b_drive}, 2'h0);
      repeat (110) @(posedge i_clock);
      awake = 1;
      chk({o_winding_a_drive, o_winding_b_drive}, 2'h3);
      rchk(OFS_DAC, 32'h16B, RESP_OKAY);
      // Every mode, random direction and step bursts, random bready stalls
      for (int md = 0; md < 4; md++) begin
         m_bits = md;
         put(0);
         for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            u_host.slow = int'(seed[5:4]);
            m_dir = int'(seed[0]);
            put(0);
            repeat (1 + int'(seed[3:1])) put(1);
         end
      end
      // Disabled: steps ignored, new mode deferred to enable rise
      m_en = 0;
      put(0);
      repeat (3) put(1);
      m_bits = 2;
      put(0);
      m_en = 1;
      put(0);
      // Read-only angle ignores writes
      u_host.wr(OFS_ANGLE, 32'h3F, resp);
      chk(resp, RESP_OKAY);
      rchk(OFS_ANGLE, m_angle, RESP_OKAY);
      // Standby returns the translator to its start angle
      m_psn = 0;
      awake = 0;
      put(0);
      put(1);
      results();
   end
endmodule // microstep_translator_tb
